// >>> verilog/lhb_host_bus.sv
// Host bus front end, display memory, refresh fetch and panel drive
`timescale 1ns/100ps

// ----------------------------------------
// Word FIFO between memory fetch and panel
// ----------------------------------------
module lhb_fifo #(
  parameter int W = 16,
  parameter int D = 32
) (
  input  wire logic         clock,
  input  wire logic         rst,
  input  wire logic         inValid,
  output logic              inReady,
  input  wire logic [W-1:0] inData,
  output logic              outValid,
  input  wire logic         outReady,
  output logic [W-1:0]      outData
);
  localparam int AW = $clog2(D);
  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0]   cnt;
  } lhb_fifo_t;
  lhb_fifo_t s_reg, s_next;
  logic [W-1:0] mem [D];
  logic push, pop;

  // Honest full and empty from the fill count
  assign inReady  = (s_reg.cnt != (AW+1)'(D));
  assign outValid = (s_reg.cnt != '0);
  assign outData  = mem[s_reg.rp];
  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;

  // Pointer and count update
  always_comb begin
    s_next = s_reg;
    if (push) begin
      s_next.wp = (s_reg.wp == AW'(D-1)) ? '0 : s_reg.wp + 1'b1;
    end
    if (pop) begin
      s_next.rp = (s_reg.rp == AW'(D-1)) ? '0 : s_reg.rp + 1'b1;
    end
    s_next.cnt = s_reg.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  // Storage
  always_ff @(posedge clock) begin
    if (push) begin
      mem[s_reg.wp] <= inData;
    end
  end
endmodule

// ----------------------------------------
// Top of the block
// ----------------------------------------
module lhb_host_bus #(
  parameter int ADDR_W      = 26,
  parameter int LINE_PIX    = 320,
  parameter int FRAME_LINES = 240,
  parameter int FRAME_WORDS = 19200
) (
  input  wire logic              clock,
  input  wire logic              rst,
  input  wire logic [3:0]        host_config_straps,
  input  wire logic              bus_style_strap,
  input  wire logic              power_polarity_strap,
  input  wire logic [ADDR_W-1:0] hostAddr,
  input  wire logic [15:0]       hostDataIn,
  output logic [15:0]            hostDataOut,
  output logic                   hostDataOe,
  input  wire logic              chipSelectN,
  input  wire logic              readStrobeN,
  input  wire logic              write_strobe_n,
  input  wire logic              high_byte_enable_n,
  output logic                   waitN,
  input  wire logic              pixel_source_clock,
  output logic [11:0]            panel_data_out,
  output logic                   panel_frame_pulse,
  output logic                   panel_shift_clock,
  output logic                   panel_line_pulse,
  output logic                   panel_data_valid,
  output logic                   panel_power_enable
);
  typedef struct packed {
    lhb_pkg::lhb_host_t               st;
    logic                             strapDone;
    logic                             busOk;
    logic                             generic2;
    logic                             bigEnd;
    logic                             pwrHigh;
    logic                             waitN;
    logic [15:0]                      dOut;
    logic                             dOe;
    logic [lhb_pkg::REG_WORDS-1:0][15:0] regs;
    logic                             pixPrev;
    logic                             pixHalf;
    logic [lhb_pkg::DIV_W-1:0]        pixCnt;
    logic [lhb_pkg::DIV_W-1:0]        memCnt;
    logic [14:0]                      fetchAddr;
    logic                             pend;
    logic [9:0]                       col;
    logic [8:0]                       row;
    logic [11:0]                      pData;
    logic                             shift;
    logic                             line;
    logic                             frame;
    logic                             dValid;
    logic                             pwr;
  } lhb_state_t;

  lhb_state_t s_reg, s_next;
  logic [15:0] dispMem [lhb_pkg::MEM_WORDS];
  logic [15:0] memQ;
  logic        memEn, memWe;
  logic [1:0]  memBe;
  logic [14:0] memAddr;
  logic [15:0] memWd;
  logic        fifoInReady, fifoOutValid, fifoPop;
  logic [15:0] fifoOut;

  lhb_fifo #(.W(16), .D(lhb_pkg::FIFO_DEPTH)) u_fifo (
    .clock    (clock),
    .rst      (rst),
    .inValid  (s_reg.pend),
    .inReady  (fifoInReady),
    .inData   (memQ),
    .outValid (fifoOutValid),
    .outReady (fifoPop),
    .outData  (fifoOut)
  );

  // Byte swap used for big-endian lane order
  function automatic logic [15:0] swapIf(input logic sw, input logic [15:0] d);
    swapIf = sw ? {d[7:0], d[15:8]} : d;
  endfunction

  logic [15:0] winAddr;
  logic        inMem, inReg, hostReq, rdReq, wrReq, refTake, pixEdge, pixTick;
  logic [1:0]  be;
  logic [15:0] ctl;
  logic [3:0]  regIdx;

  // Address decode and strobe interpretation
  always_comb begin
    winAddr = hostAddr[lhb_pkg::WIN_BITS-1:0]; // RL1 RL4
    inMem   = (winAddr <= lhb_pkg::MEM_LAST); // RL2
    inReg   = (winAddr >= lhb_pkg::REG_FIRST); // RL3
    regIdx  = winAddr[4:1];
    rdReq   = !readStrobeN;
    // Style two: write strobe only; style one: per-byte write strobes
    wrReq   = s_reg.generic2 ? !write_strobe_n
                             : (!write_strobe_n || !high_byte_enable_n);
    hostReq = s_reg.busOk && !chipSelectN && (rdReq || wrReq);
    if (s_reg.generic2) begin
      be = {!high_byte_enable_n, !winAddr[0]}; // RL10
    end else begin
      be = rdReq ? 2'b11 : {!high_byte_enable_n, !write_strobe_n};
    end
    if (s_reg.bigEnd) begin
      be = {be[0], be[1]}; // RL9
    end
    ctl     = s_reg.regs[0];
    pixEdge = pixel_source_clock && !s_reg.pixPrev; // RL11 RL12
    pixTick = pixEdge && (!ctl[lhb_pkg::F_PIX_HALF] || s_reg.pixHalf)
              && (s_reg.pixCnt == '0);
    // Refresh fetch wins the memory port on a memory tick
    refTake = ctl[lhb_pkg::F_DISP_EN] && (s_reg.memCnt == '0)
              && fifoInReady && !s_reg.pend; // RL18
  end

  // Next state of the whole block
  always_comb begin
    s_next  = s_reg;
    memEn   = 1'b0;
    memWe   = 1'b0;
    memBe   = 2'b00;
    memAddr = s_reg.fetchAddr;
    memWd   = swapIf(s_reg.bigEnd, hostDataIn);
    fifoPop = 1'b0;

    // Capture straps once after reset release
    if (!s_reg.strapDone) begin
      s_next.strapDone = 1'b1; // RL6
      s_next.busOk     = (host_config_straps[2:0] == lhb_pkg::FAMILY_GEN); // RL8
      s_next.generic2  = bus_style_strap; // RL8
      s_next.bigEnd    = host_config_straps[3]; // RL9
      s_next.pwrHigh   = power_polarity_strap; // RL7
    end

    // Refresh fetch into the FIFO
    s_next.pend = refTake;
    if (refTake) begin
      memEn = 1'b1;
      s_next.fetchAddr = (s_reg.fetchAddr == 15'(FRAME_WORDS-1)) ? '0
                                                               : s_reg.fetchAddr + 1'b1;
    end
    if (!ctl[lhb_pkg::F_DISP_EN]) begin
      s_next.fetchAddr = '0;
    end
    s_next.memCnt = (s_reg.memCnt == '0)
                    ? (ctl[lhb_pkg::F_PORTRAIT] ? ctl[lhb_pkg::F_MEM_DIV+:lhb_pkg::DIV_W]
                                                : '0)
                    : s_reg.memCnt - 1'b1; // RL13

    // Host access sequence
    case (s_reg.st)
      lhb_pkg::HS_IDLE: begin
        s_next.dOe = 1'b0;
        if (hostReq) begin
          s_next.waitN = 1'b0; // RL18
          s_next.st    = lhb_pkg::HS_ARB;
        end
      end
      lhb_pkg::HS_ARB: begin
        if (inMem) begin
          if (!refTake) begin
            memEn   = 1'b1;
            memWe   = wrReq && !rdReq;
            memBe   = be;
            memAddr = winAddr[15:1];
            if (rdReq) begin
              s_next.st = lhb_pkg::HS_FETCH;
            end else begin
              s_next.waitN = 1'b1;
              s_next.st    = lhb_pkg::HS_DONE;
            end
          end
        end else begin
          if (inReg && wrReq && !rdReq) begin
            if (be[0]) s_next.regs[regIdx][7:0]  = memWd[7:0];
            if (be[1]) s_next.regs[regIdx][15:8] = memWd[15:8];
          end
          // Gap reads return zero, gap writes are dropped
          s_next.dOut  = inReg ? swapIf(s_reg.bigEnd, s_reg.regs[regIdx])
                               : lhb_pkg::RESET_DATA; // RL19
          s_next.dOe   = rdReq;
          s_next.waitN = 1'b1;
          s_next.st    = lhb_pkg::HS_DONE;
        end
      end
      lhb_pkg::HS_FETCH: begin
        s_next.dOut  = swapIf(s_reg.bigEnd, memQ);
        s_next.dOe   = 1'b1;
        s_next.waitN = 1'b1; // RL18
        s_next.st    = lhb_pkg::HS_DONE;
      end
      lhb_pkg::HS_DONE: begin
        if (!hostReq) begin
          s_next.dOe = 1'b0;
          s_next.st  = lhb_pkg::HS_IDLE;
        end
      end
      default: begin
        s_next.st    = lhb_pkg::HS_IDLE;
        s_next.waitN = 1'b1;
        s_next.dOe   = 1'b0;
      end
    endcase

    // Pixel clock dividers
    s_next.pixPrev = pixel_source_clock;
    if (pixEdge) begin
      s_next.pixHalf = !s_reg.pixHalf; // RL12
      if (!ctl[lhb_pkg::F_PIX_HALF] || s_reg.pixHalf) begin
        s_next.pixCnt = (s_reg.pixCnt == '0)
                        ? (ctl[lhb_pkg::F_PORTRAIT] ? ctl[lhb_pkg::F_PIX_DIV+:lhb_pkg::DIV_W]
                                                    : '0)
                        : s_reg.pixCnt - 1'b1; // RL13
      end
    end

    // Panel drive: one FIFO word per shift pulse
    s_next.shift = 1'b0;
    s_next.line  = 1'b0;
    s_next.frame = 1'b0;
    if (!ctl[lhb_pkg::F_DISP_EN]) begin
      s_next.col    = '0;
      s_next.row    = '0;
      s_next.dValid = 1'b0;
    end else if (pixTick) begin
      fifoPop       = fifoOutValid;
      s_next.dValid = fifoOutValid;
      if (fifoOutValid) begin
        s_next.pData = fifoOut[lhb_pkg::PANEL_W-1:0]; // RL14
        s_next.shift = 1'b1;
        if (s_reg.col == 10'(LINE_PIX-1)) begin // RL15
          s_next.col  = '0;
          s_next.line = 1'b1;
          if (s_reg.row == 9'(FRAME_LINES-1)) begin
            s_next.row   = '0;
            s_next.frame = 1'b1;
          end else begin
            s_next.row = s_reg.row + 1'b1;
          end
        end else begin
          s_next.col = s_reg.col + 1'b1;
        end
      end
    end
    s_next.pwr = s_reg.pwrHigh ? ctl[lhb_pkg::F_PANEL_ON]
                               : !ctl[lhb_pkg::F_PANEL_ON]; // RL7
  end

  // State register
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s_reg       <= '0;
      s_reg.st    <= lhb_pkg::HS_IDLE;
      s_reg.waitN <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  // Single-port display memory with byte writes
  always_ff @(posedge clock) begin
    if (memEn) begin
      if (memWe && memBe[0]) dispMem[memAddr][7:0]  <= memWd[7:0];
      if (memWe && memBe[1]) dispMem[memAddr][15:8] <= memWd[15:8];
      memQ <= dispMem[memAddr];
    end
  end

  // Outputs straight from the state register
  assign hostDataOut        = s_reg.dOut;
  assign hostDataOe         = s_reg.dOe;
  assign waitN              = s_reg.waitN;
  assign panel_data_out     = s_reg.pData;
  assign panel_frame_pulse  = s_reg.frame;
  assign panel_shift_clock  = s_reg.shift;
  assign panel_line_pulse   = s_reg.line;
  assign panel_data_valid   = s_reg.dValid;
  assign panel_power_enable = s_reg.pwr;
endmodule

// >>> verilog/lhb_pkg.sv
// Constants and types for the host bus decode and panel refresh block
// Notes on behaviour
// RL1: Decode 64K-byte window from low sixteen address bits
// RL2: Addresses 0 to 9FFFh reach display memory
// RL3: Addresses FFE0h to FFFFh reach control registers
// RL4: Upper address bits ignored, window repeats
// RL5: Host adds upper decoding against repeated images
// RL6: Latch straps at reset, keep bus configuration
// RL7: Fifth strap sets panel power polarity
// RL8: Family 111 plus bus-style strap picks style
// RL9: Endian strap one big, zero little
// RL10: Style two: byte-high enable, write, read strobes
// RL11: Bus clock needs no strobe phase relation
// RL12: Pixel source asynchronous, optional divide by two
// RL13: Portrait-mode pixel and memory clock dividers
// RL14: Twelve data lines plus five panel controls
// RL15: Passive and active panels up to 640x480
// RL16: Host asserts select for every slot access
// RL17: Host ties bus-style and direction inputs high
// RL18: Wait held until arbitration finishes
// RL19: Gap accesses complete harmlessly, read undefined
package lhb_pkg;
  localparam int          WIN_BITS    = 16;
  localparam logic [15:0] MEM_LAST    = 16'h9fff;
  localparam logic [15:0] REG_FIRST   = 16'hffe0;
  localparam logic [2:0]  FAMILY_GEN  = 3'h7;
  localparam int          MEM_WORDS   = 20480;
  localparam int          REG_WORDS   = 16;
  localparam logic [15:0] RESET_DATA  = 16'h0000;
  // Fields of the control word at the first register location
  localparam int          F_PANEL_ON  = 0;
  localparam int          F_PIX_HALF  = 1;
  localparam int          F_PORTRAIT  = 2;
  localparam int          F_DISP_EN   = 3;
  localparam int          F_PIX_DIV   = 4;
  localparam int          F_MEM_DIV   = 8;
  localparam int          DIV_W       = 4;
  localparam int          PANEL_W     = 12;
  localparam int          FIFO_DEPTH  = 32;

  typedef enum logic [3:0] {
    HS_IDLE  = 4'h1,
    HS_ARB   = 4'h2,
    HS_FETCH = 4'h4,
    HS_DONE  = 4'h8
  } lhb_host_t;
endpackage

// >>> bench/lhb_host_bus_monitor.sv
// Checker of host bus timing for the decode block
`timescale 1ns/100ps
// ----------------------------------------
// Host bus checker
// ----------------------------------------
module lhb_host_bus_monitor #(
  parameter int ADDR_W = 26
) (
  input wire logic              clock,
  input wire logic              rst,
  input wire logic [3:0]        host_config_straps,
  input wire logic [ADDR_W-1:0] hostAddr,
  input wire logic [15:0]       hostDataOut,
  input wire logic              hostDataOe,
  input wire logic              chipSelectN,
  input wire logic              readStrobeN,
  input wire logic              write_strobe_n,
  input wire logic              waitN
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  logic req;
  logic famOk;
  // Request at the pins and a usable bus family
  assign req   = !chipSelectN && (!readStrobeN || !write_strobe_n);
  assign famOk = host_config_straps[2:0] == 3'h7;
  // Steps of one transfer
  sequence s_take;
    $rose(req) && famOk;
  endsequence
  sequence s_answer;
    !waitN ##[1:12] waitN;
  endsequence
  sequence s_quiet;
    !req && !$past(req) && !$past(req, 2);
  endsequence
  a_take_wait_low: assert property (s_take |=> !waitN)
    else $error("wait not asserted after request");
  a_wait_bounded: assert property (s_take |=> s_answer)
    else $error("wait not released in time");
  a_short_answer: assert property ((s_take and hostAddr[15:0] >= 16'ha000)
    |=> !waitN ##1 waitN)
    else $error("register or gap access not answered in two cycles");
  a_refuse_family: assert property (!famOk |-> waitN && !hostDataOe)
    else $error("access answered with wrong bus family");
  a_oe_on_read: assert property ($rose(hostDataOe) |-> req && !readStrobeN && waitN)
    else $error("data driven without read strobe");
  a_gap_reads_zero: assert property ($rose(hostDataOe) && hostAddr[15:0] >= 16'ha000
    && hostAddr[15:0] <= 16'hffdf |-> hostDataOut == 16'h0000)
    else $error("gap read not zero");
  a_idle_quiet: assert property (s_quiet |-> waitN && !hostDataOe)
    else $error("bus not idle after release");
  a_wait_stands: assert property ($rose(waitN) && req |=> waitN)
    else $error("wait dropped while cycle held");
endmodule

bind lhb_host_bus lhb_host_bus_monitor #(.ADDR_W(ADDR_W)) lhb_host_bus_monitor_inst (
  .clock, .rst, .host_config_straps, .hostAddr, .hostDataOut, .hostDataOe,
  .chipSelectN, .readStrobeN, .write_strobe_n, .waitN);

// >>> bench/lhb_host_model.sv
// Host processor model driving the strobe bus
`timescale 1ns/100ps
// ----------------------------------------
// Host model
// ----------------------------------------
module lhb_host_model (
  input  wire logic        clock,
  input  wire logic        waitN,
  input  wire logic [15:0] hostDataOut,
  output logic [25:0]      hostAddr,
  output logic [15:0]      hostDataIn,
  output logic             chipSelectN,
  output logic             readStrobeN,
  output logic             write_strobe_n,
  output logic             high_byte_enable_n
);
  // Idle bus with released strobes
  initial begin
    hostAddr = 26'h0;
    hostDataIn = 16'h0;
    chipSelectN = 1'b1;
    readStrobeN = 1'b1;
    write_strobe_n = 1'b1;
    high_byte_enable_n = 1'b1;
  end
  // One cycle, held until the wait line releases it or 20 cycles pass
  task automatic access(input logic wr, input logic [25:0] a, input logic [15:0] d,
                        input logic hb, output logic [15:0] q, output logic ok);
    int n;
    logic seenLow;
    n = 0;
    seenLow = 1'b0;
    ok = 1'b0;
    q = 16'h0;
    @(posedge clock);
    hostAddr <= a;
    hostDataIn <= wr ? d : ~hostDataIn;
    high_byte_enable_n <= hb;
    chipSelectN <= 1'b0;
    readStrobeN <= wr;
    write_strobe_n <= !wr;
    while (n < 20 && !ok) begin
      @(posedge clock);
      n++;
      if (!waitN) begin
        seenLow = 1'b1;
      end else if (seenLow) begin
        ok = 1'b1;
        q = hostDataOut;
      end
    end
    // Select and strobes released; data and address lines inverted from their old values, byte-high enable kept
    chipSelectN <= 1'b1;
    readStrobeN <= 1'b1;
    write_strobe_n <= 1'b1;
    hostDataIn <= ~hostDataIn;
    hostAddr <= ~hostAddr;
    repeat (2) @(posedge clock);
  endtask
endmodule

// >>> bench/tb.sv
// Self-checking bench of the host bus decode block
`timescale 1ns/100ps
module tb;
  logic        clock, rst, bus_style_strap, power_polarity_strap, pixel_source_clock;
  logic [3:0]  host_config_straps;
  logic [25:0] hostAddr;
  logic [15:0] hostDataIn, hostDataOut, q;
  logic        hostDataOe, chipSelectN, readStrobeN, write_strobe_n, high_byte_enable_n;
  logic        waitN, ok, panel_frame_pulse, panel_shift_clock, panel_line_pulse;
  logic        panel_data_valid, panel_power_enable;
  logic [11:0] panel_data_out;
  int          n_errors = 0;
  int          n_tests = 0;
  lhb_host_bus #(.LINE_PIX(4), .FRAME_LINES(2), .FRAME_WORDS(8)) lhb_host_bus_inst (
    .clock, .rst, .host_config_straps, .bus_style_strap, .power_polarity_strap, .hostAddr,
    .hostDataIn, .hostDataOut, .hostDataOe, .chipSelectN, .readStrobeN, .write_strobe_n,
    .high_byte_enable_n, .waitN, .pixel_source_clock, .panel_data_out, .panel_frame_pulse,
    .panel_shift_clock, .panel_line_pulse, .panel_data_valid, .panel_power_enable);
  lhb_host_model lhb_host_model_inst (.clock, .waitN, .hostDataOut, .hostAddr, .hostDataIn,
    .chipSelectN, .readStrobeN, .write_strobe_n, .high_byte_enable_n);
  // ----------------------------------------
  // Clocks, compare and bus tasks
  // ----------------------------------------
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  // Pixel source unrelated to the bus clock, never toggling on a clock edge
  initial begin
    pixel_source_clock = 1'b0;
    #0.3;
    forever #37 pixel_source_clock = ~pixel_source_clock;
  end
  task check(input string name, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", name, exp, got);
    end
  endtask
  task do_reset(input logic [3:0] s, input logic pol);
    @(posedge clock);
    rst <= 1'b1;
    host_config_straps <= s;
    power_polarity_strap <= pol;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    repeat (2) @(posedge clock);
  endtask
  task wr(input logic [25:0] a, input logic [15:0] d, input logic hb);
    lhb_host_model_inst.access(1'b1, a, d, hb, q, ok);
    check("write answered", 16'h0001, {15'h0, ok});
  endtask
  task rd(input logic [25:0] a, input logic [15:0] exp, input string name);
    lhb_host_model_inst.access(1'b0, a, 16'h0000, 1'b0, q, ok);
    check("read answered", 16'h0001, {15'h0, ok});
    check(name, exp, q);
  endtask
  task t_registers();
    wr(26'h000ffe2, 16'h5a3c, 1'b0);
    rd(26'h000ffe2, 16'h5a3c, "register word");
    wr(26'h3ffffe4, 16'hc3a5, 1'b0);
    rd(26'h000ffe4, 16'hc3a5, "aliased write");
    rd(26'h155ffe2, 16'h5a3c, "aliased read");
    $display("registers done");
  endtask
  task t_memory();
    wr(26'h0000000, 16'h1234, 1'b0);
    wr(26'h0009ffe, 16'habcd, 1'b0);
    rd(26'h0009ffe, 16'habcd, "last memory word");
    wr(26'h0000001, 16'hee77, 1'b0);
    rd(26'h0000000, 16'hee34, "high byte write");
    wr(26'h0000000, 16'h9955, 1'b1);
    rd(26'h0000000, 16'hee55, "low byte write");
    $display("memory done");
  endtask
  task t_gap();
    wr(26'h000a000, 16'hbeef, 1'b0);
    rd(26'h000a000, 16'h0000, "gap read");
    rd(26'h0009ffe, 16'habcd, "memory after gap");
    rd(26'h000ffe2, 16'h5a3c, "register after gap");
    $display("gap done");
  endtask
  task t_power();
    check("power off high", 16'h0000, {15'h0, panel_power_enable});
    wr(26'h000ffe0, 16'h0001, 1'b0);
    check("power on high", 16'h0001, {15'h0, panel_power_enable});
    do_reset(4'h7, 1'b0);
    check("power off low", 16'h0001, {15'h0, panel_power_enable});
    wr(26'h000ffe0, 16'h0001, 1'b0);
    check("power on low", 16'h0000, {15'h0, panel_power_enable});
    $display("power done");
  endtask
  task t_family();
    do_reset(4'h3, 1'b1);
    lhb_host_model_inst.access(1'b0, 26'h0000000, 16'h0000, 1'b0, q, ok);
    check("wrong family answered", 16'h0000, {15'h0, ok});
    do_reset(4'hf, 1'b1);
    host_config_straps <= 4'h7;
    rd(26'h0009ffe, 16'hcdab, "big endian");
    do_reset(4'h7, 1'b1);
    rd(26'h0009ffe, 16'habcd, "little endian");
    $display("family done");
  endtask
  // Refresh words reach the panel in order, with line and frame pulses
  task t_panel();
    int i;
    int k;
    int cyc;
    k = 0;
    cyc = 0;
    for (i = 0; i < 8; i++) begin
      wr(26'(2 * i), 16'hfa50 + 16'(i), 1'b0);
    end
    wr(26'h000ffe0, 16'h0009, 1'b0);
    while (k < 16 && cyc < 400) begin
      @(posedge clock);
      cyc++;
      if (panel_shift_clock) begin
        check("panel data", 16'h0a50 + 16'(k % 8), {4'h0, panel_data_out});
        check("panel valid", 16'h0001, {15'h0, panel_data_valid});
        check("line pulse", {15'h0, k % 4 == 3}, {15'h0, panel_line_pulse});
        check("frame pulse", {15'h0, k % 8 == 7}, {15'h0, panel_frame_pulse});
        k++;
      end
    end
    check("panel shifts", 16'h0010, 16'(k));
    wr(26'h000ffe0, 16'h0001, 1'b0);
    $display("panel done");
  endtask
  // Style one: an odd-address write with only the low strobe hits the low byte
  task t_style();
    bus_style_strap <= 1'b0;
    do_reset(4'h7, 1'b1);
    wr(26'h0000010, 16'h2468, 1'b0);
    wr(26'h0000011, 16'h1357, 1'b1);
    lhb_host_model_inst.access(1'b0, 26'h0000010, 16'h0000, 1'b1, q, ok);
    check("style one read answered", 16'h0001, {15'h0, ok});
    check("style one byte write", 16'h2457, q);
    bus_style_strap <= 1'b1;
    do_reset(4'h7, 1'b1);
    $display("style done");
  endtask
  task finish_test();
    $display("checks %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // Watchdog against a hung bus
  initial begin
    #1000000;
    n_errors++;
    finish_test();
  end
  // Main sequence
  initial begin
    rst = 1'b1;
    host_config_straps = 4'h7;
    bus_style_strap = 1'b1;
    power_polarity_strap = 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    repeat (2) @(posedge clock);
    t_registers();
    t_memory();
    t_gap();
    t_power();
    t_family();
    t_panel();
    t_style();
    finish_test();
  end
endmodule
